// ### rtl/art_pkg.sv
// package: register map, field positions and timing constants of the auto-reload timer
package art_pkg;

  // ----------------------------------------------------------------
  // register offsets on the special-function-register bus
  // ----------------------------------------------------------------
  localparam logic [7:0] ART_ADDR_CTRL = 8'h91;
  localparam logic [7:0] ART_ADDR_RLD_LO = 8'h92;
  localparam logic [7:0] ART_ADDR_RLD_HI = 8'h93;
  localparam logic [7:0] ART_ADDR_CNT_LO = 8'h94;
  localparam logic [7:0] ART_ADDR_CNT_HI = 8'h95;

  // ----------------------------------------------------------------
  // control register fields and reset values
  // ----------------------------------------------------------------
  localparam int ART_BIT_HI_OVF = 7;
  localparam int ART_BIT_LO_OVF = 6;
  localparam int ART_BIT_LO_IRQ_EN = 5;
  localparam int ART_BIT_SPLIT = 3;
  localparam int ART_BIT_RUN = 2;
  localparam int ART_BIT_EXT_SEL = 0;
  localparam logic [7:0] ART_CTRL_RST = 8'h00;
  localparam logic [7:0] ART_CTRL_WMASK = 8'hED;
  localparam logic [7:0] ART_BYTE_RST = 8'h00;
  localparam logic [7:0] ART_BYTE_MAX = 8'hFF;

  // ----------------------------------------------------------------
  // prescaler ratios
  // ----------------------------------------------------------------
  localparam int ART_SYS_DIV = 12;
  localparam int ART_EXT_DIV = 8;

  // tick sources offered to each counter byte
  typedef struct packed {
    logic sys_div;
    logic ext_div;
  } art_ticks_t;

endpackage

// ### rtl/art_tick_if.sv
// interface: prescaler tick strobes passed from the tick generator to the timer core
interface art_tick_if;
  import art_pkg::*;

  art_ticks_t ticks;

  modport source (output ticks);
  modport sink (input ticks);
endinterface

// ### rtl/art_tick_gen.sv
// module: system-clock-divided and synchronized external-clock-divided tick strobes
module art_tick_gen
  import art_pkg::*;
#(
  parameter int SYS_DIV = ART_SYS_DIV,
  parameter int EXT_DIV = ART_EXT_DIV
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // external oscillator pin
  input wire logic ext_osc_i,
  // tick strobes
  art_tick_if.source tick_o
);

  initial begin
    if (SYS_DIV < 2 || SYS_DIV > 255 || EXT_DIV < 1 || EXT_DIV > 255) begin
      $error("art_tick_gen: divider out of range");
    end
  end

  localparam logic [7:0] SYS_LAST = 8'(SYS_DIV - 1);
  localparam logic [7:0] EXT_LAST = 8'(EXT_DIV - 1);

  typedef struct packed {
    logic [7:0] sys_cnt;
    logic [7:0] ext_cnt;
    logic sync1;
    logic sync2;
    logic osc_prev;
    art_ticks_t ticks;
  } art_gen_state_t;

  art_gen_state_t s_q;
  art_gen_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.ticks = '0;
    s_d.sync1 = ext_osc_i;
    s_d.sync2 = s_q.sync1;
    s_d.osc_prev = s_q.sync2;
    if (s_q.sys_cnt == SYS_LAST) begin
      s_d.sys_cnt = '0;
      s_d.ticks.sys_div = 1'b1;
    end else begin
      s_d.sys_cnt = s_q.sys_cnt + 8'h01;
    end
    // rising edges of the synchronized oscillator; edges faster than half of clk_i are lost
    if (s_q.sync2 && !s_q.osc_prev) begin
      if (s_q.ext_cnt == EXT_LAST) begin
        s_d.ext_cnt = '0;
        s_d.ticks.ext_div = 1'b1;
      end else begin
        s_d.ext_cnt = s_q.ext_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_o.ticks = s_q.ticks;

endmodule

// ### rtl/art_timer.sv
// module: auto-reload timer with 16-bit and split 8-bit modes and its byte registers
//
// Behaviour
// - control bit 3 clear gives one 16-bit timer, set gives two 8-bit timers.
// - 16-bit mode counts each tick, reloads both reload bytes on wrap to zero.
// - high overflow flag sets on 16-bit wrap, or high byte wrap in split mode.
// - 16-bit mode with interrupt enabled requests an interrupt on every 16-bit overflow.
// - with low interrupt enable too, low byte wrap also requests an interrupt.
// - split mode: each byte counts and reloads from its own reload byte.
// - run bit gates whole 16-bit timer; in split mode only the high byte.
// - byte clock select high means system clock, else the shared selected source.
// - external select bit picks system clock over 12 or external clock over 8.
// - external clock is synchronized before dividing; it must not exceed half the system clock.
// - low overflow flag sets on each low byte wrap, in either mode.
// - split mode interrupts on high overflow, and low too when enabled.
// - hardware never clears overflow flags; software clears and checks both.
// - control bits 4 and 1 read zero and ignore writes.
// - low reload byte is read-write, resets to zero.
// - high reload byte is read-write, resets to zero.
// - low count byte is read-write, resets to zero.
// - high count byte is read-write, resets to zero.
module art_timer
  import art_pkg::*;
#(
  parameter int SYS_DIV = ART_SYS_DIV,
  parameter int EXT_DIV = ART_EXT_DIV
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // special-function-register bus
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  // clock selection from the clock control register
  input wire logic hi_clock_select_i,
  input wire logic lo_clock_select_i,
  // external oscillator
  input wire logic ext_osc_i,
  // interrupt
  input wire logic irq_enable_i,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // tick generation
  // ----------------------------------------------------------------
  art_tick_if tick_bus ();

  art_tick_gen #(
    .SYS_DIV(SYS_DIV),
    .EXT_DIV(EXT_DIV)
  ) u_tick_gen (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ext_osc_i(ext_osc_i),
    .tick_o(tick_bus.source)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic hi_ovf;
    logic lo_ovf;
    logic lo_irq_en;
    logic split;
    logic run;
    logic ext_sel;
    logic [7:0] rld_lo;
    logic [7:0] rld_hi;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic [7:0] rdata;
    logic irq;
  } art_state_t;

  art_state_t s_q;
  art_state_t s_d;

  // one byte's tick: system clock, or the source picked by the external select bit
  function automatic logic byte_tick(input logic clk_sel, input logic ext_sel, input art_ticks_t t);
    if (clk_sel) begin
      byte_tick = 1'b1;
    end else if (ext_sel) begin
      byte_tick = t.ext_div;
    end else begin
      byte_tick = t.sys_div;
    end
  endfunction

  // control register as seen by software, unused bits zero
  function automatic logic [7:0] ctrl_view(input art_state_t s);
    ctrl_view = '0;
    ctrl_view[ART_BIT_HI_OVF] = s.hi_ovf;
    ctrl_view[ART_BIT_LO_OVF] = s.lo_ovf;
    ctrl_view[ART_BIT_LO_IRQ_EN] = s.lo_irq_en;
    ctrl_view[ART_BIT_SPLIT] = s.split;
    ctrl_view[ART_BIT_RUN] = s.run;
    ctrl_view[ART_BIT_EXT_SEL] = s.ext_sel;
  endfunction

  logic tick_lo;
  logic tick_hi;
  logic inc_lo;
  logic inc_hi;
  logic wrap_lo;
  logic wrap_hi;
  logic [7:0] wmasked;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    tick_lo = byte_tick(lo_clock_select_i, s_q.ext_sel, tick_bus.ticks);
    tick_hi = byte_tick(hi_clock_select_i, s_q.ext_sel, tick_bus.ticks);
    inc_lo = 1'b0;
    inc_hi = 1'b0;
    wrap_lo = 1'b0;
    wrap_hi = 1'b0;
    wmasked = sfr_wdata_i & ART_CTRL_WMASK;

    if (s_q.split) begin
      // low byte free-runs in split mode; run bit gates only the high byte
      inc_lo = tick_lo;
      inc_hi = tick_hi && s_q.run;
      wrap_lo = inc_lo && (s_q.cnt_lo == ART_BYTE_MAX);
      wrap_hi = inc_hi && (s_q.cnt_hi == ART_BYTE_MAX);
      if (inc_lo) begin
        s_d.cnt_lo = wrap_lo ? s_q.rld_lo : s_q.cnt_lo + 8'h01;
      end
      if (inc_hi) begin
        s_d.cnt_hi = wrap_hi ? s_q.rld_hi : s_q.cnt_hi + 8'h01;
      end
    end else begin
      // 16-bit mode takes its tick from the low byte's clock selection
      inc_lo = tick_lo && s_q.run;
      wrap_lo = inc_lo && (s_q.cnt_lo == ART_BYTE_MAX);
      wrap_hi = wrap_lo && (s_q.cnt_hi == ART_BYTE_MAX);
      if (wrap_hi) begin
        s_d.cnt_lo = s_q.rld_lo;
        s_d.cnt_hi = s_q.rld_hi;
      end else if (inc_lo) begin
        {s_d.cnt_hi, s_d.cnt_lo} = {s_q.cnt_hi, s_q.cnt_lo} + 16'h0001;
      end
    end

    // register writes; flag set below wins over a software clear
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        ART_ADDR_CTRL: begin
          s_d.hi_ovf = wmasked[ART_BIT_HI_OVF];
          s_d.lo_ovf = wmasked[ART_BIT_LO_OVF];
          s_d.lo_irq_en = wmasked[ART_BIT_LO_IRQ_EN];
          s_d.split = wmasked[ART_BIT_SPLIT];
          s_d.run = wmasked[ART_BIT_RUN];
          s_d.ext_sel = wmasked[ART_BIT_EXT_SEL];
        end
        ART_ADDR_RLD_LO: s_d.rld_lo = sfr_wdata_i;
        ART_ADDR_RLD_HI: s_d.rld_hi = sfr_wdata_i;
        ART_ADDR_CNT_LO: s_d.cnt_lo = sfr_wdata_i;
        ART_ADDR_CNT_HI: s_d.cnt_hi = sfr_wdata_i;
        default: begin
        end
      endcase
    end

    // hardware only ever sets the flags, never clears them
    if (wrap_hi) begin
      s_d.hi_ovf = 1'b1;
    end
    if (wrap_lo) begin
      s_d.lo_ovf = 1'b1;
    end

    // request stays up while an enabled flag is pending
    s_d.irq = irq_enable_i && (s_d.hi_ovf || (s_d.lo_irq_en && s_d.lo_ovf));

    // read data is registered; unmapped addresses read zero
    s_d.rdata = '0;
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        ART_ADDR_CTRL: s_d.rdata = ctrl_view(s_q);
        ART_ADDR_RLD_LO: s_d.rdata = s_q.rld_lo;
        ART_ADDR_RLD_HI: s_d.rdata = s_q.rld_hi;
        ART_ADDR_CNT_LO: s_d.rdata = s_q.cnt_lo;
        ART_ADDR_CNT_HI: s_d.rdata = s_q.cnt_hi;
        default: s_d.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sfr_rdata_o = s_q.rdata;
  assign irq_o = s_q.irq;

endmodule

// ### test/art_timer_monitor.sv
// checker: port-level assertions of the auto-reload timer
module art_timer_monitor
  import art_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register bus
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  // clock selects, oscillator and interrupt
  input wire logic hi_clock_select_i,
  input wire logic lo_clock_select_i,
  input wire logic ext_osc_i,
  input wire logic irq_enable_i,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_rdata_idle: assert property (!sfr_rd_i |=> sfr_rdata_o == 8'h00)
    else $error("read data not zero without a read");
  a_unused_zero: assert property (sfr_rd_i && sfr_addr_i == ART_ADDR_CTRL |=>
    sfr_rdata_o[4] == 1'b0 && sfr_rdata_o[1] == 1'b0) else $error("unused control bit set");
  a_unmapped_zero: assert property (sfr_rd_i && !(sfr_addr_i inside {[8'h91:8'h95]}) |=>
    sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_bytes_rw: assert property (sfr_wr_i && sfr_addr_i inside {[8'h92:8'h95]} ##1
    sfr_rd_i && sfr_addr_i == $past(sfr_addr_i) |=> sfr_rdata_o == $past(sfr_wdata_i, 2))
    else $error("byte write not read back");
  a_ctrl_mask: assert property (sfr_wr_i && sfr_addr_i == ART_ADDR_CTRL ##1
    sfr_rd_i && !sfr_wr_i && sfr_addr_i == ART_ADDR_CTRL |=>
    (sfr_rdata_o & 8'h2D) == ($past(sfr_wdata_i, 2) & 8'h2D)) else $error("control bits not kept");
  a_flag_sticky: assert property (sfr_rd_i && !sfr_wr_i && sfr_addr_i == ART_ADDR_CTRL ##1
    sfr_rd_i && !sfr_wr_i && sfr_addr_i == ART_ADDR_CTRL |=>
    (sfr_rdata_o[7:6] & $past(sfr_rdata_o[7:6])) == $past(sfr_rdata_o[7:6])) else $error("flag cleared");
  a_reload_steady: assert property (sfr_rd_i && !sfr_wr_i && sfr_addr_i inside {8'h92, 8'h93} ##1
    sfr_rd_i && !sfr_wr_i && sfr_addr_i == $past(sfr_addr_i) |=> sfr_rdata_o == $past(sfr_rdata_o))
    else $error("reload byte changed");
  a_irq_gated: assert property (irq_o |-> $past(irq_enable_i))
    else $error("interrupt without enable");
endmodule

bind art_timer art_timer_monitor mon_u (.clk_i, .sys_rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i,
  .sfr_rdata_o, .hi_clock_select_i, .lo_clock_select_i, .ext_osc_i, .irq_enable_i, .irq_o);

// ### test/art_timer_test.sv
// testbench: self-checking random and corner tests of the auto-reload timer
module art_timer_test
  import art_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, wr, rd, hs, ls, xo, ie, irq;
  logic [7:0] addr, wd, rdat, ctl, a, d;
  logic [15:0] cnt, rld;
  int fails, comparisons, n;
  art_timer dut_u (.clk_i(clk), .sys_rst_i(rst), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wd),
    .sfr_rd_i(rd), .sfr_rdata_o(rdat), .hi_clock_select_i(hs), .lo_clock_select_i(ls), .ext_osc_i(xo),
    .irq_enable_i(ie), .irq_o(irq));
  // ----------------------------------------------------------------
  // bus tasks and model
  // ----------------------------------------------------------------
  // strobes stay up until the next access or an explicit drop, so back-to-back accesses never glitch
  task automatic wreg(input logic [7:0] ad, input logic [7:0] dd);
    addr = ad; wd = dd; wr = 1'b1; rd = 1'b0;
    @(negedge clk);
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input string what, input logic [7:0] ad, input logic [7:0] exp);
    addr = ad; rd = 1'b1; wr = 1'b0;
    @(negedge clk);
    chk(what, exp, rdat);
  endtask
  function automatic void step(input bit lt, input bit ht);
    if (!ctl[3] && lt && ctl[2]) begin
      if (cnt[7:0] == 8'hFF) ctl[6] = 1'b1;
      if (cnt == 16'hFFFF) begin
        ctl[7] = 1'b1;
        cnt = rld;
      end else cnt = cnt + 16'h0001;
    end
    if (ctl[3] && lt) begin
      if (cnt[7:0] == 8'hFF) ctl[6] = 1'b1;
      cnt[7:0] = (cnt[7:0] == 8'hFF) ? rld[7:0] : cnt[7:0] + 8'h01;
    end
    if (ctl[3] && ht && ctl[2]) begin
      if (cnt[15:8] == 8'hFF) ctl[7] = 1'b1;
      cnt[15:8] = (cnt[15:8] == 8'hFF) ? rld[15:8] : cnt[15:8] + 8'h01;
    end
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #50us;
    fails++;
    tally_and_finish();
  end
  initial begin
    {rst, wr, rd, hs, ls, xo, ie} = 7'b1000000;
    addr = 8'h00; wd = 8'h00; fails = 0; comparisons = 0;
    void'($urandom(94444));
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (int i = 8'h90; i <= 8'h96; i++) rchk("reset", 8'(i), 8'h00);
    $display("test reset done");
    wreg(ART_ADDR_CTRL, 8'h0D);
    {hs, ls} = 2'b11;
    for (int i = 0; i < 8; i++) begin
      a = ART_ADDR_RLD_LO + 8'(i % 4);
      d = 8'($urandom);
      wreg(a, d);
      rchk("byte", a, d);
      if (i % 4 < 2) rchk("byte", a, d);
    end
    {hs, ls} = 2'b00;
    repeat (4) begin
      d = 8'($urandom) | 8'h01;
      wreg(ART_ADDR_CTRL, d);
      rchk("control", ART_ADDR_CTRL, d & 8'hED);
    end
    wreg(ART_ADDR_CTRL, 8'h00);
    $display("test registers done");
    repeat (6) begin
      ctl = {2'b00, 1'($urandom), 1'b0, 1'($urandom), 1'($urandom), 1'b0, 1'b1};
      ctl[5] = ctl[5] & ctl[3];
      cnt = {8'hF8 | 8'($urandom), 8'hF0 | 8'($urandom)};
      rld = 16'($urandom);
      ie = 1'($urandom);
      wreg(ART_ADDR_RLD_LO, rld[7:0]);
      wreg(ART_ADDR_RLD_HI, rld[15:8]);
      wreg(ART_ADDR_CNT_LO, cnt[7:0]);
      wreg(ART_ADDR_CNT_HI, cnt[15:8]);
      wreg(ART_ADDR_CTRL, ctl);
      n = 1 + $urandom % 24;
      {wr, ls} = 2'b01;
      repeat (n) @(negedge clk);
      ls = 1'b0;
      repeat (n) step(1'b1, 1'b0);
      n = 1 + $urandom % 24;
      hs = 1'b1;
      repeat (n) @(negedge clk);
      hs = 1'b0;
      repeat (n) step(1'b0, 1'b1);
      chk("irq", {7'h00, ie & (ctl[7] | (ctl[5] & ctl[6]))}, {7'h00, irq});
      rchk("count_lo", ART_ADDR_CNT_LO, cnt[7:0]);
      rchk("count_hi", ART_ADDR_CNT_HI, cnt[15:8]);
      rchk("control", ART_ADDR_CTRL, ctl);
      rchk("control", ART_ADDR_CTRL, ctl);
      wreg(ART_ADDR_CTRL, 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
    end
    $display("test counting done");
    wreg(ART_ADDR_CNT_LO, 8'h00);
    wreg(ART_ADDR_CTRL, 8'h04);
    wr = 1'b0;
    repeat (120) @(negedge clk);
    // 120 running edges always hold exactly 120/12 prescaler strobes, whatever the divider phase
    rchk("div12", ART_ADDR_CNT_LO, 8'(120 / ART_SYS_DIV));
    rchk("div12_hi", ART_ADDR_CNT_HI, cnt[15:8]);
    wreg(ART_ADDR_CNT_LO, 8'h00);
    wreg(ART_ADDR_CTRL, 8'h05);
    wr = 1'b0;
    repeat (160) begin
      @(negedge clk);
      xo = ~xo;
    end
    rd = 1'b0;
    @(negedge clk);
    addr = ART_ADDR_CNT_LO;
    rd = 1'b1;
    @(negedge clk);
    chk("ext8", 8'h01, {7'h00, rdat inside {[8'd9:8'd11]}});
    $display("test prescalers done");
    tally_and_finish();
  end
endmodule
